// file: disk_ctrl_consts.svh
// constants for the disk controller phase and fifo flow block
`ifndef DISK_CTRL_CONSTS_SVH
`define DISK_CTRL_CONSTS_SVH
`define FIFO_DEPTH        5'h10
`define MODE_AT           2'h0
`define MODE_SECOND_GEN   2'h1
`define MODE_LEGACY       2'h2
`define CFG_MODE_HI       3
`define CFG_MODE_LO       2
`define CFG_BURST_BIT     1
`define CMD_PARAM_COUNT   4'h3
`define RESULT_COUNT      3'h3
`define CMD_READ_DATA     8'h06
`define CMD_WRITE_DATA    8'h05
`define CMD_SENSE_INT     8'h08
`define CMD_CONFIGURE     8'h13
`define CMD_SPECIFY       8'h03
`define STATUS_INVALID    8'h80
`define STATUS_NORMAL     8'h00
`define STATUS_ABNORMAL   8'h40
`endif

// file: disk_ctrl_phase_fifo_flow.sv
// command, execution and result phase engine with fifo service flow control
// Overview of operation
// - pin reset clears all state except the specify dma mode bit and the fifo data contents
// - pin reset sets the output-register reset bit; host clears it to leave reset
// - both software resets reinitialise the core and the fifo
// - rate reset self clears; output reset holds and has precedence
// - two-bit mode field selects at, second-gen or legacy compatibility
// - at mode: dma bit gates interrupt and dma; density active high
// - second-gen mode: dma bit ignored, always enabled; density active low
// - legacy mode: dma bit gates interrupt and dma; density active low
// - specify picks dma or pio; config bit picks burst over single
// - master drops after each command write, returns per parameter unless illegal
// - after last parameter master stays low, controller advances itself
// - fifo disabled after reset and in command phase; configure may enable it
// - threshold equals parameter plus one, range 1 to 16
// - pio read: request at 16 minus threshold bytes or sector end, drop on empty
// - pio write: request on entry until full, again at threshold, result on drain
// - dma read: request at 16 minus threshold or sector end, drop on empty
// - dma write: request on entry until full, again at threshold, end on count
// - transfer ends on terminal count, overrun/underrun or end of track
// - terminal count mid sector completes sector (code: only if still high at sector end or the cycle before); implicit ends report abnormal
// - result starts with interrupt; host reads all bytes while both flags are 1
// - invalid first command byte raises interrupt; sense reports invalid
// - any reset leaves power-down
`include "disk_ctrl_consts.svh"
module disk_ctrl_phase_fifo_flow
  import disk_ctrl_pkg::*;
(
  input  wire logic       clk_in,
  input  wire logic       arst_n_in,
  input  wire logic       dor_reset_wr_in,
  input  wire logic       dor_reset_val_in,
  input  wire logic       dor_dma_enable_in,
  input  wire logic       rate_reset_wr_in,
  input  wire logic [3:0] fdc_config_reg_in,
  input  wire logic       high_density_in,
  input  wire logic       host_wr_in,
  input  wire logic       host_rd_in,
  input  wire logic [7:0] host_wdata_in,
  input  wire logic       terminal_count_in,
  input  wire logic       overrun_in,
  input  wire logic       disk_take_in,
  input  wire logic       disk_give_in,
  input  wire logic [7:0] disk_data_in,
  input  wire logic       sector_end_in,
  input  wire logic       last_sector_in,
  output logic [7:0]      host_rdata_out,
  output logic            request_for_master_flag_out,
  output logic            transfer_direction_flag_out,
  output logic            controller_busy_flag_out,
  output logic            non_dma_flag_out,
  output logic            interrupt_out,
  output logic            dma_request_out,
  output logic            burst_mode_out,
  output logic            density_select_out,
  output logic            dor_reset_out,
  output logic            power_down_out,
  output logic [7:0]      disk_data_out,
  output logic [4:0]      fifo_count_out,
  output logic            fifo_enabled_out
);
  //////////////////////////////////////////////////////////////////////////////
  // reset sources
  logic       dor_reset_reg;
  logic       rate_reset_reg;
  logic       core_reset;
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      dor_reset_reg <= 1'b1;
    end else if (dor_reset_wr_in) begin
      dor_reset_reg <= dor_reset_val_in;
    end
  end
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rate_reset_reg <= 1'b0;
    end else begin
      rate_reset_reg <= rate_reset_wr_in;
    end
  end
  assign core_reset = dor_reset_reg | rate_reset_reg;
  //////////////////////////////////////////////////////////////////////////////
  // mode gating
  logic [1:0] mode;
  logic       gate_en;
  assign mode = fdc_config_reg_in[`CFG_MODE_HI:`CFG_MODE_LO];
  always_comb begin
    case (mode)
      `MODE_SECOND_GEN: gate_en = 1'b1;
      default:          gate_en = dor_dma_enable_in;
    endcase
  end
  //////////////////////////////////////////////////////////////////////////////
  // phase engine
  phase_e     state_reg;
  logic [7:0] opcode_reg;
  logic [3:0] param_cnt_reg;
  logic [7:0] last_param_reg;
  logic [2:0] result_cnt_reg;
  logic [7:0] status_reg;
  logic       invalid_pending_reg;
  logic       dma_mode_reg;
  logic       fifo_on_reg;
  logic [3:0] thr_param_reg;
  logic       writing_reg;
  logic       stalled_reg;
  logic [4:0] count_reg;
  logic [4:0] threshold;
  logic       done_reg;
  logic       fifo_push;
  logic       fifo_pop;
  logic [7:0] fifo_mem [0:15];
  logic [3:0] wr_ptr_reg;
  logic [3:0] rd_ptr_reg;
  assign threshold = {1'b0, thr_param_reg} + 5'h01;
  always_ff @(posedge clk_in) begin
    if (state_reg == ST_CMD_PROC && opcode_reg == `CMD_SPECIFY) begin
      dma_mode_reg <= ~last_param_reg[0]; // kept across pin reset
    end
  end
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state_reg           <= ST_RESET;
      opcode_reg          <= 8'h00;
      param_cnt_reg       <= 4'h0;
      last_param_reg      <= 8'h00;
      result_cnt_reg      <= 3'h0;
      status_reg          <= 8'h00;
      invalid_pending_reg <= 1'b0;
      fifo_on_reg         <= 1'b0;
      thr_param_reg       <= 4'h0;
      writing_reg         <= 1'b0;
      done_reg            <= 1'b0;
    end else if (core_reset) begin
      state_reg           <= ST_RESET;
      param_cnt_reg       <= 4'h0;
      result_cnt_reg      <= 3'h0;
      invalid_pending_reg <= 1'b0;
      fifo_on_reg         <= 1'b0;
      thr_param_reg       <= 4'h0;
      done_reg            <= 1'b0;
    end else begin
      case (state_reg)
        ST_RESET: state_reg <= ST_CMD_WAIT;
        ST_CMD_WAIT: begin
          if (host_wr_in) begin
            if (param_cnt_reg == 4'h0) begin
              opcode_reg <= host_wdata_in;
            end
            last_param_reg <= host_wdata_in;
            param_cnt_reg  <= param_cnt_reg + 4'h1;
            state_reg      <= ST_CMD_PROC;
          end
        end
        ST_CMD_PROC: begin
          done_reg <= 1'b0;
          if (opcode_reg != `CMD_READ_DATA && opcode_reg != `CMD_WRITE_DATA &&
              opcode_reg != `CMD_SENSE_INT && opcode_reg != `CMD_CONFIGURE &&
              opcode_reg != `CMD_SPECIFY) begin
            invalid_pending_reg <= 1'b1;
            status_reg          <= `STATUS_INVALID;
            param_cnt_reg       <= 4'h0;
            state_reg           <= ST_CMD_WAIT;
          end else if (opcode_reg == `CMD_SENSE_INT) begin
            status_reg          <= invalid_pending_reg ? `STATUS_INVALID : status_reg;
            invalid_pending_reg <= 1'b0;
            param_cnt_reg       <= 4'h0;
            result_cnt_reg      <= 3'h0;
            state_reg           <= ST_RESULT;
          end else if (param_cnt_reg < `CMD_PARAM_COUNT) begin
            state_reg <= ST_CMD_WAIT;
          end else begin
            param_cnt_reg <= 4'h0;
            if (opcode_reg == `CMD_CONFIGURE) begin
              fifo_on_reg   <= last_param_reg[4];
              thr_param_reg <= last_param_reg[3:0];
              state_reg     <= ST_CMD_WAIT;
            end else if (opcode_reg == `CMD_SPECIFY) begin
              state_reg <= ST_CMD_WAIT;
            end else begin
              writing_reg <= (opcode_reg == `CMD_WRITE_DATA);
              state_reg   <= ST_EXEC;
            end
          end
        end
        ST_EXEC: begin
          if (sector_end_in && (terminal_count_in || last_sector_in || stalled_reg ||
              overrun_in)) begin
            done_reg <= 1'b1;
            status_reg <= terminal_count_in ? `STATUS_NORMAL : `STATUS_ABNORMAL;
          end
          if (done_reg && count_reg == 5'h00) begin
            result_cnt_reg <= 3'h0;
            state_reg      <= ST_RESULT;
          end
        end
        ST_RESULT: begin
          if (host_rd_in) begin
            result_cnt_reg <= result_cnt_reg + 3'h1;
            if (result_cnt_reg == `RESULT_COUNT - 3'h1 || opcode_reg == `CMD_SENSE_INT) begin
              state_reg <= ST_CMD_WAIT;
              done_reg  <= 1'b0;
            end
          end
        end
        default: state_reg <= ST_RESET;
      endcase
    end
  end
  // terminal count seen during execution, registered one cycle later
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      stalled_reg <= 1'b0;
    end else begin
      stalled_reg <= (state_reg == ST_EXEC) && terminal_count_in;
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  // fifo
  logic exec;
  logic host_side_rd;
  logic host_side_wr;
  assign exec         = (state_reg == ST_EXEC);
  assign host_side_wr = exec && writing_reg && host_wr_in && count_reg != `FIFO_DEPTH;
  assign host_side_rd = exec && !writing_reg && host_rd_in && count_reg != 5'h00;
  assign fifo_push = host_side_wr || (exec && !writing_reg && disk_give_in &&
                     count_reg != `FIFO_DEPTH);
  assign fifo_pop  = host_side_rd || (exec && writing_reg && disk_take_in &&
                     count_reg != 5'h00);
  always_ff @(posedge clk_in) begin
    if (fifo_push) begin
      fifo_mem[wr_ptr_reg] <= writing_reg ? host_wdata_in : disk_data_in;
    end
  end
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      wr_ptr_reg <= 4'h0;
      rd_ptr_reg <= 4'h0;
      count_reg  <= 5'h00;
    end else if (core_reset || !exec) begin
      wr_ptr_reg <= 4'h0;
      rd_ptr_reg <= 4'h0;
      count_reg  <= 5'h00;
    end else begin
      if (fifo_push) begin
        wr_ptr_reg <= wr_ptr_reg + 4'h1;
      end
      if (fifo_pop) begin
        rd_ptr_reg <= rd_ptr_reg + 4'h1;
      end
      count_reg <= count_reg + {4'h0, fifo_push} - {4'h0, fifo_pop};
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  // service request flow
  logic req_reg;
  logic req_next;
  logic eff_thr_lvl;
  assign eff_thr_lvl = fifo_on_reg ? 1'b0 : 1'b1;
  always_comb begin
    req_next = req_reg;
    if (!exec || done_reg && writing_reg) begin
      req_next = 1'b0;
    end else if (writing_reg) begin
      if (count_reg == `FIFO_DEPTH) begin
        req_next = 1'b0;
      end else if (!req_reg && count_reg <= (eff_thr_lvl ? 5'h0F : threshold)) begin
        req_next = 1'b1;
      end
    end else begin
      if (count_reg == 5'h00) begin
        req_next = 1'b0;
      end else if (count_reg >= (eff_thr_lvl ? 5'h01 : `FIFO_DEPTH - threshold) ||
                   sector_end_in) begin
        req_next = 1'b1;
      end
    end
  end
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      req_reg <= 1'b0;
    end else begin
      req_reg <= req_next;
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  // outputs
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      request_for_master_flag_out <= 1'b0;
      transfer_direction_flag_out <= 1'b0;
      controller_busy_flag_out    <= 1'b0;
      non_dma_flag_out            <= 1'b0;
      interrupt_out               <= 1'b0;
      dma_request_out             <= 1'b0;
      burst_mode_out              <= 1'b0;
      density_select_out          <= 1'b0;
      dor_reset_out               <= 1'b1;
      power_down_out              <= 1'b0;
      host_rdata_out              <= 8'h00;
      disk_data_out               <= 8'h00;
      fifo_count_out              <= 5'h00;
      fifo_enabled_out            <= 1'b0;
    end else begin
      request_for_master_flag_out <= (state_reg == ST_CMD_WAIT) || (state_reg == ST_RESULT) ||
                                     (exec && !dma_mode_reg && req_next);
      transfer_direction_flag_out <= (state_reg == ST_RESULT) || (exec && !writing_reg);
      controller_busy_flag_out    <= (state_reg == ST_CMD_PROC) || exec ||
                                     (state_reg == ST_RESULT) ||
                                     (state_reg == ST_CMD_WAIT && param_cnt_reg != 4'h0);
      non_dma_flag_out            <= exec && !dma_mode_reg;
      interrupt_out               <= gate_en && ((state_reg == ST_RESULT) ||
                                     invalid_pending_reg ||
                                     (exec && !dma_mode_reg && req_next));
      dma_request_out             <= gate_en && exec && dma_mode_reg && req_next;
      burst_mode_out              <= fdc_config_reg_in[`CFG_BURST_BIT];
      density_select_out          <= (mode == `MODE_AT) ? high_density_in : ~high_density_in;
      dor_reset_out               <= dor_reset_reg;
      power_down_out              <= power_down_out && !core_reset;
      host_rdata_out              <= exec ? fifo_mem[rd_ptr_reg] : status_reg;
      disk_data_out               <= fifo_mem[rd_ptr_reg];
      fifo_count_out              <= count_reg;
      fifo_enabled_out            <= fifo_on_reg && exec;
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  // assertions
  property p_reset_hold;
    @(posedge clk_in) disable iff (!arst_n_in)
      dor_reset_reg |=> state_reg == ST_RESET;
  endproperty
  a_reset_hold: assert property (p_reset_hold) else $error("reset state left early");
  property p_rate_self_clear;
    @(posedge clk_in) disable iff (!arst_n_in)
      rate_reset_wr_in ##1 !rate_reset_wr_in |=> !rate_reset_reg;
  endproperty
  a_rate_self_clear: assert property (p_rate_self_clear) else $error("rate reset stuck");
  property p_fifo_cmd_off;
    @(posedge clk_in) disable iff (!arst_n_in)
      state_reg == ST_CMD_WAIT |=> count_reg == 5'h00;
  endproperty
  a_fifo_cmd_off: assert property (p_fifo_cmd_off) else $error("fifo active in command");
  property p_master_drop;
    @(posedge clk_in) disable iff (!arst_n_in)
      state_reg == ST_CMD_WAIT && host_wr_in && !core_reset |=> ##1 !request_for_master_flag_out;
  endproperty
  a_master_drop: assert property (p_master_drop) else $error("master flag not dropped");
  property p_second_gen_gate;
    @(posedge clk_in) disable iff (!arst_n_in)
      mode == `MODE_SECOND_GEN && state_reg == ST_RESULT |=> interrupt_out;
  endproperty
  a_second_gen_gate: assert property (p_second_gen_gate) else $error("gate not forced");
  property p_read_empty_drop;
    @(posedge clk_in) disable iff (!arst_n_in)
      exec && !writing_reg && count_reg == 5'h00 |=> !req_reg;
  endproperty
  a_read_empty_drop: assert property (p_read_empty_drop) else $error("request on empty");
  property p_write_full_drop;
    @(posedge clk_in) disable iff (!arst_n_in)
      exec && writing_reg && count_reg == `FIFO_DEPTH |=> !req_reg;
  endproperty
  a_write_full_drop: assert property (p_write_full_drop) else $error("request on full");
  property p_result_ready;
    @(posedge clk_in) disable iff (!arst_n_in)
      state_reg == ST_RESULT && host_rd_in && !core_reset &&
      result_cnt_reg == `RESULT_COUNT - 3'h1 |=> ##1
      request_for_master_flag_out && !transfer_direction_flag_out;
  endproperty
  a_result_ready: assert property (p_result_ready) else $error("not ready after result");
  c_exec:   cover property (@(posedge clk_in) state_reg == ST_EXEC);
  c_result: cover property (@(posedge clk_in) state_reg == ST_RESULT);
  c_dma:    cover property (@(posedge clk_in) dma_request_out);
  c_inval:  cover property (@(posedge clk_in) invalid_pending_reg);
endmodule : disk_ctrl_phase_fifo_flow

// file: disk_ctrl_phase_fifo_flow_tb.sv
// self-checking bench for the disk controller phase and fifo flow block
`include "disk_ctrl_consts.svh"
module disk_ctrl_phase_fifo_flow_tb
  import disk_ctrl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk_in, arst_n_in, dor_reset_wr_in, dor_reset_val_in, dor_dma_enable_in;
  logic rate_reset_wr_in, high_density_in, host_wr_in, host_rd_in, terminal_count_in;
  logic overrun_in, disk_take_in, disk_give_in, sector_end_in, last_sector_in;
  logic [3:0] fdc_config_reg_in;
  logic [7:0] host_wdata_in, disk_data_in, host_rdata_out, disk_data_out;
  logic master, dir, busy, non_dma, intr, dreq, burst, dens, dor_rst, pdown, fifo_en;
  logic [4:0] fifo_count_out;
  int err_total = 0;
  int n_tests = 0;
  int n;
  logic [6:0] rows [6] = '{7'h06, 7'h17, 7'h24, 7'h22, 7'h55, 7'h42};

  disk_ctrl_phase_fifo_flow dut_u (.clk_in(clk_in), .arst_n_in(arst_n_in),
    .dor_reset_wr_in(dor_reset_wr_in), .dor_reset_val_in(dor_reset_val_in),
    .dor_dma_enable_in(dor_dma_enable_in), .rate_reset_wr_in(rate_reset_wr_in),
    .fdc_config_reg_in(fdc_config_reg_in), .high_density_in(high_density_in),
    .host_wr_in(host_wr_in), .host_rd_in(host_rd_in), .host_wdata_in(host_wdata_in),
    .terminal_count_in(terminal_count_in), .overrun_in(overrun_in),
    .disk_take_in(disk_take_in), .disk_give_in(disk_give_in), .disk_data_in(disk_data_in),
    .sector_end_in(sector_end_in), .last_sector_in(last_sector_in),
    .host_rdata_out(host_rdata_out), .request_for_master_flag_out(master),
    .transfer_direction_flag_out(dir), .controller_busy_flag_out(busy),
    .non_dma_flag_out(non_dma), .interrupt_out(intr), .dma_request_out(dreq),
    .burst_mode_out(burst), .density_select_out(dens), .dor_reset_out(dor_rst),
    .power_down_out(pdown), .disk_data_out(disk_data_out), .fifo_count_out(fifo_count_out),
    .fifo_enabled_out(fifo_en));

  host_dma_model host_u (.clk_in(clk_in), .master_in(master), .dir_in(dir),
    .dma_req_in(dreq), .rdata_in(host_rdata_out), .wr_out(host_wr_in),
    .rd_out(host_rd_in), .wdata_out(host_wdata_in));

  initial begin
    clk_in = 1'b0;
    forever #20 clk_in = ~clk_in;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic summarize();
    if (err_total == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : summarize

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic need(input logic ok);
    chk({7'h00, ok}, 8'h01);
    if (ok !== 1'b1) summarize();
  endtask : need

  // sel 0 ready for a command, 1 interrupt, 2 dma request
  task automatic wait_for(input int sel);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < 300 && !hit; i++) begin
      @(negedge clk_in);
      hit = (sel == 0) ? (master === 1'b1 && dir === 1'b0) : (sel == 1) ? (intr === 1'b1)
            : (dreq === 1'b1);
    end
    need(hit);
  endtask : wait_for

  task automatic send(input logic [7:0] b0, b1, b2, input int cnt);
    logic ok;
    logic [7:0] b [3];
    b = '{b0, b1, b2};
    for (int i = 0; i < cnt; i++) begin
      host_u.put(b[i], ok);
      need(ok);
      @(negedge clk_in);
      chk({7'h00, master}, 8'h00);
    end
  endtask : send

  task automatic results(input int cnt, input logic [7:0] exp);
    logic ok;
    logic [7:0] v;
    for (int i = 0; i < cnt; i++) begin
      host_u.get(v, ok);
      need(ok);
      chk(v, exp);
    end
    wait_for(0);
    chk({6'h00, dir, busy}, 8'h00);
  endtask : results

  task automatic disk(input logic give, input int cnt);
    for (int i = 0; i < cnt; i++) begin
      disk_give_in = give;
      disk_take_in = !give;
      disk_data_in = 8'hA0 + i[7:0];
      @(negedge clk_in);
      disk_give_in = 1'b0;
      disk_take_in = 1'b0;
      @(negedge clk_in);
    end
  endtask : disk

  task automatic pulse_end(input logic tc, input logic end_of_track_param);
    terminal_count_in = tc;
    last_sector_in = end_of_track_param;
    sector_end_in = 1'b1;
    @(negedge clk_in);
    sector_end_in = 1'b0;
    wait_for(1);
  endtask : pulse_end

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {arst_n_in, dor_reset_wr_in, dor_reset_val_in, dor_dma_enable_in} = 4'h0;
    {rate_reset_wr_in, high_density_in, terminal_count_in, overrun_in} = 4'h0;
    {disk_take_in, disk_give_in, sector_end_in, last_sector_in} = 4'h0;
    fdc_config_reg_in = 4'h0;
    disk_data_in = 8'h00;
    repeat (5) @(negedge clk_in);
    chk({4'h0, dor_rst, master, fifo_en, pdown}, 8'h08);
    arst_n_in = 1'b1;
    @(negedge clk_in);
    dor_reset_wr_in = 1'b1;
    @(negedge clk_in);
    dor_reset_wr_in = 1'b0;
    wait_for(0);
    chk({7'h00, dor_rst}, 8'h00);
    foreach (rows[i]) begin
      fdc_config_reg_in = rows[i][6:3];
      high_density_in = rows[i][2];
      repeat (2) @(negedge clk_in);
      chk({7'h00, dens}, {7'h00, rows[i][1]});
      chk({7'h00, burst}, {7'h00, rows[i][0]});
    end
    // pio read, threshold four
    fdc_config_reg_in = 4'h0;
    dor_dma_enable_in = 1'b1;
    send(8'h13, 8'h00, 8'h13, 3);
    wait_for(0);
    chk({7'h00, fifo_en}, 8'h00);
    send(8'h03, 8'h00, 8'h01, 3);
    wait_for(0);
    send(8'h06, 8'h00, 8'h00, 3);
    repeat (4) @(negedge clk_in);
    chk({6'h00, fifo_en, non_dma}, 8'h03);
    disk(1'b1, 11);
    chk({1'h0, master, intr, fifo_count_out}, 8'h0B);
    disk(1'b1, 1);
    wait_for(1);
    chk({6'h00, master, dir}, 8'h03);
    for (int i = 0; i < 12; i++) begin
      logic ok;
      logic [7:0] v;
      host_u.get(v, ok);
      need(ok);
      chk(v, (i < 11) ? 8'hA0 + i[7:0] : 8'hA0);
    end
    repeat (3) @(negedge clk_in);
    chk({1'h0, master, intr, fifo_count_out}, 8'h00);
    pulse_end(1'b1, 1'b0);
    results(3, 8'h00);
    terminal_count_in = 1'b0;
    // dma write, second-gen mode ignores the dma enable bit
    fdc_config_reg_in = 4'h4;
    dor_dma_enable_in = 1'b0;
    send(8'h03, 8'h00, 8'h00, 3);
    wait_for(0);
    send(8'h05, 8'h00, 8'h00, 3);
    wait_for(2);
    chk({7'h00, non_dma}, 8'h00);
    host_u.dma(1'b1, 1, n);
    chk(n[7:0], 8'h10);
    chk({2'h0, dreq, fifo_count_out}, 8'h10);
    disk(1'b0, 11);
    chk({7'h00, dreq}, 8'h00);
    chk(disk_data_out, 8'h0B);
    disk(1'b0, 1);
    wait_for(2);
    terminal_count_in = 1'b1;
    disk(1'b0, 4);
    pulse_end(1'b1, 1'b0);
    results(3, 8'h00);
    terminal_count_in = 1'b0;
    // dma read ended at end of track
    send(8'h06, 8'h00, 8'h00, 3);
    repeat (4) @(negedge clk_in);
    disk(1'b1, 11);
    chk({7'h00, dreq}, 8'h00);
    disk(1'b1, 1);
    wait_for(2);
    host_u.dma(1'b0, 0, n);
    chk(n[7:0], 8'h0C);
    repeat (3) @(negedge clk_in);
    chk({2'h0, dreq, fifo_count_out}, 8'h00);
    pulse_end(1'b0, 1'b1);
    results(3, 8'h40);
    last_sector_in = 1'b0;
    // illegal opcode
    send(8'hFF, 8'h00, 8'h00, 1);
    wait_for(1);
    send(8'h08, 8'h00, 8'h00, 1);
    results(1, 8'h80);
    // software resets; output-register reset wins over rate reset
    dor_reset_val_in = 1'b1;
    dor_reset_wr_in = 1'b1;
    rate_reset_wr_in = 1'b1;
    @(negedge clk_in);
    {dor_reset_wr_in, rate_reset_wr_in, dor_reset_val_in} = 3'h0;
    repeat (10) @(negedge clk_in);
    chk({5'h00, dor_rst, master, fifo_en}, 8'h04);
    dor_reset_wr_in = 1'b1;
    @(negedge clk_in);
    dor_reset_wr_in = 1'b0;
    wait_for(0);
    rate_reset_wr_in = 1'b1;
    @(negedge clk_in);
    rate_reset_wr_in = 1'b0;
    repeat (2) @(negedge clk_in);
    chk({7'h00, master}, 8'h00);
    wait_for(0);
    chk({6'h00, dor_rst, pdown}, 8'h00);
    summarize();
  end
endmodule : disk_ctrl_phase_fifo_flow_tb

// file: disk_ctrl_pkg.sv
// types for the disk controller phase and fifo flow block
package disk_ctrl_pkg;
  typedef enum logic [2:0] {
    ST_RESET,
    ST_CMD_WAIT,
    ST_CMD_PROC,
    ST_EXEC,
    ST_RESULT
  } phase_e;
endpackage : disk_ctrl_pkg

// file: host_dma_model.sv
// host processor and system dma controller model facing the disk controller
module host_dma_model (
  input  wire logic       clk_in,
  input  wire logic       master_in,
  input  wire logic       dir_in,
  input  wire logic       dma_req_in,
  input  wire logic [7:0] rdata_in,
  output logic            wr_out,
  output logic            rd_out,
  output logic [7:0]      wdata_out
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    wr_out = 1'b0;
    rd_out = 1'b0;
    wdata_out = 8'h00;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // programmed byte cycles, gated on the status flags
  task automatic put(input logic [7:0] val, output logic ok);
    ok = 1'b0;
    for (int i = 0; i < 200 && !ok; i++) begin
      @(negedge clk_in);
      ok = (master_in === 1'b1) && (dir_in === 1'b0);
    end
    if (ok) begin
      wr_out = 1'b1;
      wdata_out = val;
      @(negedge clk_in);
      wr_out = 1'b0;
      wdata_out = ~val;
    end
  endtask : put

  task automatic get(output logic [7:0] val, output logic ok);
    ok = 1'b0;
    val = 8'h00;
    for (int i = 0; i < 200 && !ok; i++) begin
      @(negedge clk_in);
      ok = (master_in === 1'b1) && (dir_in === 1'b1);
    end
    if (ok) begin
      rd_out = 1'b1;
      @(negedge clk_in);
      rd_out = 1'b0;
      val = rdata_in;
    end
  endtask : get

  ////////////////////////////////////////////////////////////////////////////////
  // dma service while the request stands; gap idles make a slow controller
  task automatic dma(input logic wr, input int gap, output int n);
    n = 0;
    while (dma_req_in === 1'b1 && n < 40) begin
      wr_out = wr;
      rd_out = !wr;
      wdata_out = n[7:0];
      @(negedge clk_in);
      wr_out = 1'b0;
      rd_out = 1'b0;
      wdata_out = ~n[7:0];
      n++;
      repeat (gap + 1) @(negedge clk_in);
    end
  endtask : dma
endmodule : host_dma_model
